// ==== rtl/lrpf_regs.vh ====
// lrpf_regs.vh: constants for the link receive phase FIFO.
// assumes inclusion by lrpf_top.v only; definitions, no logic.
`ifndef LRPF_REGS_VH
`define LRPF_REGS_VH
// default storage depth (entries) and pointer width
`define LRPF_DEPTH        16
`define LRPF_PTR_W        4
// default link word width (command/address/data lanes)
`define LRPF_DATA_W       8
// default write-to-read separation at init, in entries
`define LRPF_INIT_SEP     8
// cycles that the idle-low detector costs before init fires
`define LRPF_SYNC_LAT     2
// low samples on the lanes needed before the read pointer starts
`define LRPF_IDLE_CNT     4
// clocking modes
`define LRPF_MODE_SYNC    1'b0
`define LRPF_MODE_PSYNC   1'b1
`endif

// ==== rtl/lrpf_top.v ====
// lrpf_top.v: receive elastic FIFO from the forwarded link clock to the core clock.
// assumes the forwarded clock, control lane and lanes arrive asynchronously on pins;
// the core clock samples them and finds forwarded-clock rising edges itself.
`timescale 1ns/100ps
`include "lrpf_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - every link word after pointer init is moved into core domain
// - writes and reads both on forwarded clock edges
// - separation margins absorb phase drift between domains
// - depth holds all words until read
// - write-to-read gap lets entries settle first
// - read-to-overwrite gap prevents early overwrite
// - init resets read pointer, offsets write pointer
// - mode chooses fixed or adjusted read pointer
// - synchronous mode: set once, never corrected
// - pseudo-synchronous: hold read pointer to keep gap
// - init only after lanes seen low in core
// - detection latency subtracted from starting offset
module lrpf_top #(
	parameter DATA_W   = `LRPF_DATA_W,
	parameter DEPTH    = `LRPF_DEPTH,
	parameter PTR_W    = `LRPF_PTR_W,
	parameter INIT_SEP = `LRPF_INIT_SEP,
	parameter SYNC_LAT = `LRPF_SYNC_LAT,
	parameter IDLE_CNT = `LRPF_IDLE_CNT
) (
	input  wire              core_clk_in,
	input  wire              rst_b_in,
	input  wire              clk_en_in,
	input  wire              link_init_in,
	input  wire              clock_mode_in,
	input  wire              link_forwarded_clock_in,
	input  wire              control_lane_in,
	input  wire [DATA_W-1:0] command_address_data_lanes_in,
	output reg               rx_valid_out,
	output reg  [DATA_W-1:0] rx_data_out,
	output reg               rx_control_out,
	output reg               ptr_init_done_out,
	output reg               sep_error_out
);

	// start offset; detection latency is already spent, so it is removed
	localparam [PTR_W-1:0] START_SEP = INIT_SEP - SYNC_LAT;
	localparam [PTR_W-1:0] SEP_MIN   = START_SEP - 1'b1;
	localparam [PTR_W-1:0] SEP_MAX   = START_SEP + 1'b1;
	localparam [2:0] IDLE_CNT_V      = IDLE_CNT;

	localparam ST_WAIT_LOW = 2'd0;
	localparam ST_RUN      = 2'd1;

	////////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every pin except rst_b_in and clk_en_in
	reg               fclk_s1_q;
	reg               fclk_s2_q;
	reg               fclk_s3_q;
	reg               ctl_s1_q;
	reg               ctl_s2_q;
	reg               ctl_s3_q;
	reg  [DATA_W-1:0] cad_s1_q;
	reg  [DATA_W-1:0] cad_s2_q;
	reg  [DATA_W-1:0] cad_s3_q;
	reg               init_s1_q;
	reg               init_s2_q;
	reg               mode_s1_q;
	reg               mode_s2_q;

	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fclk_s1_q <= 1'b0;
			fclk_s2_q <= 1'b0;
			fclk_s3_q <= 1'b0;
			ctl_s1_q  <= 1'b0;
			ctl_s2_q  <= 1'b0;
			ctl_s3_q  <= 1'b0;
			cad_s1_q  <= {DATA_W{1'b0}};
			cad_s2_q  <= {DATA_W{1'b0}};
			cad_s3_q  <= {DATA_W{1'b0}};
			init_s1_q <= 1'b0;
			init_s2_q <= 1'b0;
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
		end else if (clk_en_in) begin
			fclk_s1_q <= link_forwarded_clock_in;
			fclk_s2_q <= fclk_s1_q;
			fclk_s3_q <= fclk_s2_q;
			ctl_s1_q  <= control_lane_in;
			ctl_s2_q  <= ctl_s1_q;
			ctl_s3_q  <= ctl_s2_q;
			cad_s1_q  <= command_address_data_lanes_in;
			cad_s2_q  <= cad_s1_q;
			cad_s3_q  <= cad_s2_q;
			init_s1_q <= link_init_in;
			init_s2_q <= init_s1_q;
			mode_s1_q <= clock_mode_in;
			mode_s2_q <= mode_s1_q;
		end
	end

	// data delayed one more stage so it lines up with the detected edge
	wire fclk_rise = fclk_s2_q & ~fclk_s3_q;

	////////////////////////////////////////////////////////////////////////////////
	// storage, written per forwarded-clock edge
	reg  [DATA_W:0]  mem_q [0:DEPTH-1];
	reg  [PTR_W-1:0] wr_ptr_q;
	reg  [PTR_W-1:0] rd_ptr_q;
	reg  [1:0]       state_q;
	reg  [2:0]       idle_q;
	reg              hold_q;
	wire [PTR_W-1:0] gap = wr_ptr_q - rd_ptr_q;
	wire             lanes_low = ~ctl_s2_q & ~(|cad_s2_q);
	wire             rd_fire   = ~init_s2_q & (state_q == ST_RUN) & fclk_rise & ~hold_q;
	wire             sep_lost  = (gap == {PTR_W{1'b0}}) || (gap > SEP_MAX + 2'd2);

	// margin picture with the defaults: write leads read by START_SEP entries,
	// leaving DEPTH - START_SEP entries of read-to-overwrite room.
	// a gap from one entry up to SEP_MAX + 2 entries is absorbed; beyond that the
	// sticky error says a margin was lost, and only link_init or reset clears it.

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
			// cleared at reset so the first reads after init show zeros, not unknowns
			always @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					mem_q[gi] <= {(DATA_W+1){1'b0}};
				end else if (clk_en_in && fclk_rise && wr_ptr_q == gi) begin
					mem_q[gi] <= {ctl_s3_q, cad_s3_q};
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// pointer control
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_q          <= {PTR_W{1'b0}};
			rd_ptr_q          <= {PTR_W{1'b0}};
			state_q           <= ST_WAIT_LOW;
			idle_q            <= 3'h0;
			hold_q            <= 1'b0;
			ptr_init_done_out <= 1'b0;
		end else if (clk_en_in) begin
			hold_q       <= 1'b0;
			if (fclk_rise) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (init_s2_q) begin
				// link initialisation: restart and wait for idle lanes
				state_q           <= ST_WAIT_LOW;
				idle_q            <= 3'h0;
				ptr_init_done_out <= 1'b0;
			end else begin
				case (state_q)
				ST_WAIT_LOW: begin
					if (fclk_rise) begin
						if (!lanes_low) begin
							idle_q <= 3'h0;
						end else if (idle_q != IDLE_CNT_V) begin
							idle_q <= idle_q + 3'h1;
						end
					end
					if (idle_q == IDLE_CNT_V) begin
						wr_ptr_q          <= START_SEP;
						rd_ptr_q          <= {PTR_W{1'b0}};
						state_q           <= ST_RUN;
						ptr_init_done_out <= 1'b1;
					end
				end
				ST_RUN: begin
					// pseudo-sync slips one read when the gap runs short
					if (mode_s2_q == `LRPF_MODE_PSYNC && gap < SEP_MIN) begin
						hold_q <= 1'b1;
					end
					// read once per forwarded edge; sync mode never corrects
					if (rd_fire) begin
						rd_ptr_q <= rd_ptr_q + 1'b1;
					end
				end
				default: state_q <= ST_WAIT_LOW;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read word register, one pulse per read
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_valid_out   <= 1'b0;
			rx_data_out    <= {DATA_W{1'b0}};
			rx_control_out <= 1'b0;
		end else if (clk_en_in) begin
			rx_valid_out <= rd_fire;
			if (rd_fire) begin
				rx_data_out    <= mem_q[rd_ptr_q][DATA_W-1:0];
				rx_control_out <= mem_q[rd_ptr_q][DATA_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// margins lost in either direction mean corruption risk
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sep_error_out <= 1'b0;
		end else if (clk_en_in) begin
			if (init_s2_q) begin
				sep_error_out <= 1'b0;
			end else if (state_q == ST_RUN && sep_lost) begin
				sep_error_out <= 1'b1;
			end
		end
	end

endmodule

// ==== test/lrpf_tx_model.sv ====
// far-end transmitter model
// assumes run_in starts the link clock
`timescale 1ns/100ps
module lrpf_tx_model (
	input  wire logic       run_in,
	input  wire logic       idle_in,
	output logic            fclk_out,
	output logic            ctl_out,
	output logic [7:0]      lanes_out
);
	logic [7:0] n = 8'h00;
	initial begin
		fclk_out = 1'b0;
		ctl_out = 1'b0;
		lanes_out = 8'h00;
		forever begin
			wait (run_in);
			// lanes move half a period before the rise
			n = idle_in ? 8'h00 : n + 8'h01;
			lanes_out = n;
			ctl_out = n[0];
			#62.5 fclk_out = 1'b1;
			#62.5 fclk_out = 1'b0;
		end
	end
endmodule

// ==== test/lrpf_top_sva.sv ====
// port checks for lrpf_top
// assumes link rises over 8 core cycles apart
`timescale 1ns/100ps
module lrpf_top_sva #(parameter DATA_W = 8) (
	input wire              core_clk_in,
	input wire              rst_b_in,
	input wire              link_init_in,
	input wire              link_forwarded_clock_in,
	input wire              control_lane_in,
	input wire [DATA_W-1:0] command_address_data_lanes_in,
	input wire              rx_valid_out,
	input wire [DATA_W-1:0] rx_data_out,
	input wire              ptr_init_done_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence quiet3; !link_init_in [*3]; endsequence
	sequence init4; link_init_in [*4]; endsequence
	early_read_a: assert property (rx_valid_out |-> ptr_init_done_out)
		else $error("early read");
	read_gap_a: assert property (rx_valid_out |=> !rx_valid_out [*8])
		else $error("reads too close");
	data_hold_a: assert property (!rx_valid_out |-> $stable(rx_data_out))
		else $error("data moved");
	init_clear_a: assert property (init4 |=> !ptr_init_done_out && !rx_valid_out)
		else $error("init kept");
	done_hold_a: assert property (quiet3 ##0 ptr_init_done_out |=> ptr_init_done_out)
		else $error("done dropped");
	idle_first_a: assert property ($rose(ptr_init_done_out) |->
		$past(command_address_data_lanes_in, 4) == 0 && !$past(control_lane_in, 4))
		else $error("lanes not low");
	first_read_a: assert property ($rose(ptr_init_done_out) |-> ##[1:20] rx_valid_out)
		else $error("no read");
	edge_read_a: assert property ($rose(rx_valid_out) |->
		$past(link_forwarded_clock_in, 2) || $past(link_forwarded_clock_in, 3))
		else $error("read without rise");
endmodule
bind lrpf_top lrpf_top_sva #(.DATA_W(DATA_W)) u_sva (.core_clk_in(core_clk_in),
	.rst_b_in(rst_b_in), .link_init_in(link_init_in), .rx_data_out(rx_data_out),
	.link_forwarded_clock_in(link_forwarded_clock_in), .control_lane_in(control_lane_in),
	.command_address_data_lanes_in(command_address_data_lanes_in),
	.rx_valid_out(rx_valid_out), .ptr_init_done_out(ptr_init_done_out));

// ==== test/lrpf_top_tb.sv ====
// bench for lrpf_top
// assumes lrpf_tx_model on the link pins
`timescale 1ns/100ps
module lrpf_top_tb;
	logic       clk = 0, rst_b = 0, init = 0, mode = 0, run = 0, idle = 1;
	logic       fclk, ctl, vld, rctl, done, serr;
	logic [7:0] lanes, rdat;
	int         miscompares = 0, total_checks = 0, cyc = 0;
	always #5 clk = ~clk;
	lrpf_tx_model tx (.run_in(run), .idle_in(idle), .fclk_out(fclk), .ctl_out(ctl),
		.lanes_out(lanes));
	lrpf_top dut (.core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(1'b1), .link_init_in(init),
		.clock_mode_in(mode), .link_forwarded_clock_in(fclk), .control_lane_in(ctl),
		.command_address_data_lanes_in(lanes), .rx_valid_out(vld), .rx_data_out(rdat),
		.rx_control_out(rctl), .ptr_init_done_out(done), .sep_error_out(serr));
	task chk(input string nm, input logic [7:0] e, g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test;
		end
	end
	task t_init(input logic m);
		int i;
		init <= 1'b1;
		mode <= m;
		repeat (4) @(posedge clk);
		init <= 1'b0;
		for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk);
		chk("done", 8'h01, {7'h00, done});
		chk("idle wait", 8'h01, {7'h00, i >= 36});
		$display("init mode %0d ended", m);
	endtask
	task t_stream;
		logic [7:0] e;
		e = 8'h01;
		idle <= 1'b0;
		for (int k = 0; k < 600 && e < 8'h11; k++) begin
			@(posedge clk);
			#1;
			if (vld === 1'b1 && (e > 8'h01 || rdat === 8'h01)) begin
				chk("data", e, rdat);
				chk("ctl", {7'h00, e[0]}, {7'h00, rctl});
				e++;
			end
		end
		chk("count", 8'h11, e);
		@(posedge clk);
		idle <= 1'b1;
		// idle words flush old entries before the next init
		repeat (300) @(posedge clk);
		chk("sep", 8'h00, {7'h00, serr});
		$display("stream mode %0d ended", mode);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		run <= 1'b1;
		repeat (3) @(posedge clk);
		t_init(1'b0);
		t_stream;
		t_init(1'b1);
		t_stream;
		rst_b <= 1'b0;
		@(posedge clk);
		#1;
		chk("reset", 8'h00, {5'h00, vld, done, serr});
		end_of_test;
	end
endmodule
